// *** design/rmj_exec.sv ***
// rmj_exec: executes the rotate-mask relative jump on the program counter.
// assumes the decoder holds instr and start for one cycle and the register
// file answers srcData combinationally for srcSel; one clock is one T-state.
`timescale 1ns/1ps
module rmj_exec
    import rmj_pkg::*;
#(
    parameter int PCW = PC_W
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic start,
    input wire logic [INSTR_W-1:0] instr,
    input wire logic imemWait,
    input wire logic [PCW-1:0] pcIn,
    output logic [SEL_W-1:0] srcSel,
    output logic srcRead,
    input wire logic [DATA_W-1:0] srcData,
    output logic illegal,
    output logic busy,
    output logic pcLoad,
    output logic [PCW-1:0] pcOut,
    output logic [DATA_W-1:0] dispOut
);
    // the byte is sign-extended into the pc, so the pc is at least a byte
    if (PCW < DATA_W) begin : gBadPcw
        $error("rmj_exec needs a pc at least a byte wide");
    end
    // the three-bit state counter reaches at most eight T-states
    if (BASE_TSTATES < 1 || BASE_TSTATES > 8) begin : gBadTstates
        $error("rmj_exec counts one to eight T-states");
    end
    rmj_state_e state_q, state_d;
    logic [2:0] tcnt_q;
    logic [2:0] mask_q;
    logic [2:0] rot_q;
    logic [SEL_W-1:0] sel_q;
    logic [DATA_W-1:0] copy_q;
    logic [DATA_W-1:0] disp_q;
    logic [PCW-1:0] pc_q;
    logic [PCW-1:0] target_q;
    logic loaded_q;
    logic illegal_q;

    // instruction fields, sliced once so every user sees the same bits
    wire [OPC_HI-OPC_LO:0] fieldPrefix = instr[OPC_HI:OPC_LO];
    wire [MASK_HI-MASK_LO:0] fieldMask = instr[MASK_HI:MASK_LO];
    wire [ROT_HI-ROT_LO:0] fieldRot = instr[ROT_HI:ROT_LO];
    wire [SEL_W-1:0] fieldSel = instr[SEL_HI:SEL_LO];
    wire isJump = fieldPrefix == OPC_PREFIX;
    wire isIdle = state_q == RMJ_IDLE;
    wire isExec = state_q == RMJ_EXEC;
    wire isDone = state_q == RMJ_DONE;
    wire accept = start && isIdle;
    wire take = accept && isJump;
    wire illegal_d = accept && !isJump;
    wire lastT = (tcnt_q == TCNT_LAST) && !imemWait;
    // each wait cycle holds the count, so it lengthens the instruction by one T-state
    wire stepT = isExec && !imemWait && !lastT;
    wire capture = isExec && !loaded_q;
    wire [DATA_W-1:0] masked;
    // a size cast of the signed byte copies bit 7 into the upper pc bits
    wire [PCW-1:0] extended = PCW'($signed(masked));
    wire [PCW-1:0] sum = pc_q + extended;

    // only a read select is issued; no pop strobe exists, so every
    // source register keeps its value
    assign srcSel = accept ? fieldSel : sel_q;
    assign srcRead = take;

    rmj_rotmask #(
        .W(DATA_W)
    ) uRotMask (
        .dataIn(copy_q),
        .rotCount(rot_q),
        .maskCount(mask_q),
        .dataOut(masked)
    );

    always_comb begin
        state_d = state_q;
        case (state_q)
            RMJ_IDLE: begin
                if (accept && isJump) begin
                    state_d = RMJ_EXEC;
                end
            end
            RMJ_EXEC: begin
                if (lastT) begin
                    state_d = RMJ_DONE;
                end
            end
            RMJ_DONE: begin
                state_d = RMJ_IDLE;
            end
            default: begin
                state_d = RMJ_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_q <= RMJ_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // T-state counter stalls while instruction memory waits
    wire [2:0] tcnt_d = stepT ? tcnt_q + 3'h1 : tcnt_q;
    always_ff @(posedge clk) begin
        if (srst || accept) begin
            tcnt_q <= TCNT_ZERO;
        end else begin
            tcnt_q <= tcnt_d;
        end
    end

    // operands freeze at the accepting edge; the copy is private and is
    // never written back, so the source register keeps its value
    wire [2:0] mask_d = take ? fieldMask : mask_q;
    wire [2:0] rot_d = take ? fieldRot : rot_q;
    wire [SEL_W-1:0] sel_d = take ? fieldSel : sel_q;
    wire [DATA_W-1:0] copy_d = take ? srcData : copy_q;
    wire [PCW-1:0] pc_d = take ? pcIn : pc_q;

    always_ff @(posedge clk) begin
        if (srst) begin
            mask_q <= '0;
        end else begin
            mask_q <= mask_d;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            rot_q <= '0;
        end else begin
            rot_q <= rot_d;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            sel_q <= '0;
        end else begin
            sel_q <= sel_d;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            copy_q <= '0;
        end else begin
            copy_q <= copy_d;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            pc_q <= PCW'(PC_RESET);
        end else begin
            pc_q <= pc_d;
        end
    end

    // target computed once from the frozen copy; waits cannot change it
    wire loaded_d = capture || loaded_q;
    wire [DATA_W-1:0] disp_d = capture ? masked : disp_q;
    wire [PCW-1:0] target_d = capture ? sum : target_q;

    always_ff @(posedge clk) begin
        if (srst || accept) begin
            loaded_q <= 1'b0;
        end else begin
            loaded_q <= loaded_d;
        end
    end

    always_ff @(posedge clk) begin
        if (srst || accept) begin
            disp_q <= '0;
        end else begin
            disp_q <= disp_d;
        end
    end

    always_ff @(posedge clk) begin
        if (srst || accept) begin
            target_q <= PCW'(PC_RESET);
        end else begin
            target_q <= target_d;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            illegal_q <= 1'b0;
        end else begin
            illegal_q <= illegal_d;
        end
    end

    assign busy = isExec;
    assign pcLoad = isDone;
    assign pcOut = target_q;
    assign dispOut = disp_q;
    assign illegal = illegal_q;
endmodule : rmj_exec

// *** design/rmj_rotmask.sv ***
// rmj_rotmask: rotate right and mask a private displacement byte.
// assumes the operands are stable while the result is captured.
`timescale 1ns/1ps
module rmj_rotmask
    import rmj_pkg::*;
#(
    parameter int W = DATA_W
) (
    input wire logic [W-1:0] dataIn,
    input wire logic [2:0] rotCount,
    input wire logic [2:0] maskCount,
    output logic [W-1:0] dataOut
);
    // the mask field counts to seven, so only a byte is served
    if (W != DATA_W) begin : gBadWidth
        $error("rmj_rotmask serves only an 8-bit byte");
    end
    wire [2*W-1:0] doubled = {dataIn, dataIn};
    wire [2*W-1:0] shifted = doubled >> rotCount;
    wire [W-1:0] rotated = shifted[W-1:0];
    wire [W-1:0] keepMask;
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : gMask
            // bit 0 always cleared, top maskCount bits cleared
            if (i == 0) begin : gLsb
                assign keepMask[i] = 1'b0;
            end else begin : gBit
                assign keepMask[i] = (32'(W - 1 - i) >= 32'(maskCount));
            end
        end
    endgenerate
    assign dataOut = rotated & keepMask;
endmodule : rmj_rotmask

// *** inc/rmj_pkg.sv ***
// rmj_pkg: constants for the rotate-mask relative jump execution block.
// assumes a 16-bit instruction word and an 8-bit register file.
package rmj_pkg;
    localparam int DATA_W = 8;
    localparam int PC_W = 16;
    localparam int INSTR_W = 16;
    localparam int SEL_W = 5;
    // instruction field positions
    localparam int OPC_HI = 15;
    localparam int OPC_LO = 11;
    localparam int MASK_HI = 10;
    localparam int MASK_LO = 8;
    localparam int ROT_HI = 7;
    localparam int ROT_LO = 5;
    localparam int SEL_HI = 4;
    localparam int SEL_LO = 0;
    localparam logic [4:0] OPC_PREFIX = 5'h10;
    // T-state count of the instruction without wait states
    localparam int BASE_TSTATES = 4;
    localparam int CLK_MHZ = 200;
    localparam logic [2:0] TCNT_LAST = 3'(BASE_TSTATES - 1);
    localparam logic [2:0] TCNT_ZERO = 3'h0;
    localparam logic [PC_W-1:0] PC_RESET = 16'h0000;
    typedef enum logic [1:0] {
        RMJ_IDLE = 2'b00,
        RMJ_EXEC = 2'b01,
        RMJ_DONE = 2'b10
    } rmj_state_e;
endpackage : rmj_pkg

// *** sim/rmj_exec_monitor.sv ***
// rmj_exec_monitor: port checks on the jump block.
// assumes pcIn holds until pcLoad.
`timescale 1ns/1ps
module rmj_exec_monitor
    import rmj_pkg::*;
#(
    parameter int PCW = PC_W
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic start,
    input wire logic [15:0] instr,
    input wire logic imemWait,
    input wire logic [PCW-1:0] pcIn,
    input wire logic [4:0] srcSel,
    input wire logic srcRead,
    input wire logic illegal,
    input wire logic busy,
    input wire logic pcLoad,
    input wire logic [PCW-1:0] pcOut,
    input wire logic [7:0] dispOut
);
    wire acc = start && !busy && !pcLoad;
    wire ok = instr[OPC_HI:OPC_LO] == OPC_PREFIX;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    a_take_start: assert property (acc && ok |=> busy)
        else $error("no busy");
    a_lsb_zero: assert property (dispOut[0] == 1'b0)
        else $error("lsb set");
    a_pc_sum: assert property (
        pcLoad |-> pcOut == pcIn + PCW'($signed(dispOut))) else $error("sum");
    a_four_states: assert property (
        acc && ok ##1 (!imemWait) [*4] |=> pcLoad) else $error("late");
    a_wait_stall: assert property (busy && imemWait |=> busy)
        else $error("no stall");
    a_load_pulse: assert property (pcLoad |=> !pcLoad && !busy)
        else $error("load");
    a_bad_prefix: assert property (acc && !ok |=> illegal && !busy)
        else $error("prefix");
    a_read_once: assert property (
        srcRead |-> acc && srcSel == instr[4:0]) else $error("read");
    a_illegal_once: assert property (illegal |=> !illegal)
        else $error("illegal held");
endmodule : rmj_exec_monitor
bind rmj_exec rmj_exec_monitor #(.PCW(PCW)) u_mon (
    .clk(clk),
    .srst(srst),
    .start(start),
    .instr(instr),
    .imemWait(imemWait),
    .pcIn(pcIn),
    .srcSel(srcSel),
    .srcRead(srcRead),
    .illegal(illegal),
    .busy(busy),
    .pcLoad(pcLoad),
    .pcOut(pcOut),
    .dispOut(dispOut)
);

// *** sim/rmj_exec_tb.sv ***
// rmj_exec_tb: self-checking bench, regs model and bound monitor.
`timescale 1ns/1ps
module rmj_exec_tb
    import rmj_pkg::*;
;
    logic clk = 1'b0, srst = 1'b1, start = 1'b0, imemWait = 1'b0;
    logic [15:0] instr = 16'h0000, pcIn = 16'h0000, pcOut;
    logic [4:0] srcSel;
    logic [7:0] srcData, dispOut;
    logic srcRead, illegal, busy, pcLoad;
    logic [31:0] rnd = 32'hA7EF, n, notes[$];
    int fail_count = 0, n_compared = 0, cyc = 0;
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin \
    fail_count++; $display("Error %0t got %h", $time, a); end end
    always #2.5 clk = ~clk;
    rmj_exec u_dut (
        .clk(clk),
        .srst(srst),
        .start(start),
        .instr(instr),
        .imemWait(imemWait),
        .pcIn(pcIn),
        .srcSel(srcSel),
        .srcRead(srcRead),
        .srcData(srcData),
        .illegal(illegal),
        .busy(busy),
        .pcLoad(pcLoad),
        .pcOut(pcOut),
        .dispOut(dispOut)
    );
    rmj_regs_model u_regs (
        .srcSel(srcSel),
        .srcRead(srcRead),
        .srcData(srcData)
    );
    function automatic logic [31:0] lfsr(logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    task automatic op(logic [7:0] d, logic [2:0] r, m, logic [1:0] w);
        logic [7:0] t;
        t = 8'({d, d} >> r) & (8'hFF >> m) & 8'hFE;
        rnd = lfsr(rnd);
        u_regs.regs[rnd[4:0]] = d;
        notes.push_back({rnd[31:16] + 16'($signed(t)), t, 8'(4 + w)});
        @(negedge clk);
        instr = {5'h10, m, r, rnd[4:0]};
        pcIn = rnd[31:16];
        start = 1'b1;
        @(negedge clk);
        if (w != 2'h0) begin
            start = w[1]; // refused while busy
            imemWait = 1'b1;
            repeat (w) @(negedge clk);
        end
        start = 1'b0;
        imemWait = 1'b0;
        for (int i = 0; i < 40 && pcLoad !== 1'b1; i++) @(negedge clk);
        `CHK(pcLoad, 1'b1)
    endtask : op
    always @(negedge clk) begin
        if (busy === 1'b1) cyc++;
        if (pcLoad === 1'b1 || illegal === 1'b1) begin
            `CHK(notes.size() != 0, 1'b1)
            n = notes.pop_front();
            `CHK({pcOut, dispOut, 8'(cyc)}, n)
            cyc = 0;
        end
    end
    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : results
    initial begin
        #20000;
        fail_count++;
        results();
    end
    initial begin
        repeat (16) @(negedge clk);
        srst = 1'b0;
        op(8'h10, 3'h3, 3'h3, 2'h0);
        $display("test 1 done");
        for (int i = 0; i < 64; i++) begin
            rnd = lfsr(rnd);
            op(rnd[7:0], i[2:0], i[5:3], rnd[9:8]);
        end
        $display("test 2 done");
        notes.push_back(32'h0);
        @(negedge clk);
        instr = 16'h7FFF;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        repeat (4) @(negedge clk);
        $display("test 3 done");
        `CHK(notes.size(), 0)
        results();
    end
endmodule : rmj_exec_tb

// *** sim/rmj_regs_model.sv ***
// rmj_regs_model: register file read through srcSel.
`timescale 1ns/1ps
module rmj_regs_model
    import rmj_pkg::*;
(
    input wire logic [SEL_W-1:0] srcSel,
    input wire logic srcRead,
    output logic [DATA_W-1:0] srcData
);
    logic [DATA_W-1:0] regs [32]; // no write path
    // stale reads see inverted data
    assign srcData = srcRead ? regs[srcSel] : ~regs[srcSel];
endmodule : rmj_regs_model
